// ===== src/lpmc_ctrl.sv
// Low-power mode controller with Avalon-MM register slave
`timescale 1ns/10ps
`include "lpmc_defs.svh"
module lpmc_ctrl
    import lpmc_pkg::*;
#(
    parameter int STAB_CYC = `LPMC_STAB_CYC
) (
    input  wire logic        mclk,            // Oscillator clock
    input  wire logic        reset_n,         // Async reset, active low
    input  wire logic        ext_reset_n,     // Reset pin, active low
    input  wire logic        stop_disable,    // Deep sleep option off
    input  wire logic        primary_ext_interrupt,      // Pin, active low
    input  wire logic        secondary_ext_interrupt_a,  // Pin
    input  wire logic        secondary_ext_interrupt_b,  // Pin
    input  wire logic        serial_irq,      // Serial bus interrupt
    input  wire logic        prog_timer_irq,  // 16-bit timer interrupt
    input  wire logic [3:0]  avs_address,     // Word address
    input  wire logic        avs_read,        // Read strobe
    input  wire logic        avs_write,       // Write strobe
    input  wire logic [31:0] avs_writedata,   // Write data
    output logic [31:0]      avs_readdata,    // Read data
    output logic             avs_waitrequest, // Wait
    output logic             bus_clk_en,      // Half-rate bus enable
    output logic             cpu_run,         // Processor may execute
    output logic             osc_run,         // Oscillator enabled
    output logic             int_mask,        // Processor interrupt mask
    output logic [15:0]      port_dir,        // Port direction, 1 output
    output logic             sys_reset_n,     // Internal reset, active low
    output logic             irq              // Interrupt level
);
    logic [2:0]  s_rst, s_p, s_a, s_b;
    logic        rst_pin, pin_p, pin_a, pin_b, pin_p_d, pin_a_d, pin_b_d;
    logic [15:0] por_cnt;
    logic        por_done;
    lpmc_state_e state;
    logic [31:0] stab_cnt;
    logic [`LPMC_PRESC_W-1:0] presc;
    logic [7:0]  core_timer_ctrl_status;
    logic        primary_irq_edge_select;
    logic [1:0]  sec_sens [2];
    logic [1:0]  sec_en;
    logic [`LPMC_EV_N-1:0] status, mask, ev;
    logic        ext_req, p_req;
    logic [1:0]  s_req;
    logic        deep_cmd, light_cmd, timer_irq, acc;

    // Two-flop synchronisers
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_rst <= 3'h0;
            s_p   <= 3'h7;
            s_a   <= 3'h0;
            s_b   <= 3'h0;
        end else begin
            s_rst <= {s_rst[1:0], ext_reset_n};
            s_p   <= {s_p[1:0], primary_ext_interrupt};
            s_a   <= {s_a[1:0], secondary_ext_interrupt_a};
            s_b   <= {s_b[1:0], secondary_ext_interrupt_b};
        end
    end
    assign rst_pin = s_rst[1];
    assign pin_p   = s_p[1];
    assign pin_a   = s_a[1];
    assign pin_b   = s_b[1];
    assign pin_p_d = s_p[2];
    assign pin_a_d = s_a[2];
    assign pin_b_d = s_b[2];

    // Internal power-on reset and pin reset
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            por_cnt  <= 16'h0000;
            por_done <= 1'b0;
        end else if (!por_done) begin
            por_cnt  <= por_cnt + 16'h0001;
            por_done <= (por_cnt == 16'(`LPMC_POR_CYC - 1)); // [RL3]
        end
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            sys_reset_n <= 1'b0;
        else
            sys_reset_n <= por_done & rst_pin; // [RL2] [RL3]
    end
    wire srst = !(por_done & rst_pin);

    // Bus clock enable at half rate, held low while the oscillator is off
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            bus_clk_en <= 1'b0;
        else if (srst || !osc_run)
            bus_clk_en <= 1'b0; // [RL4]
        else
            bus_clk_en <= !bus_clk_en; // [RL1]
    end

    // Register bus decode
    assign acc = (avs_read | avs_write) & avs_waitrequest;
    // Write lands on the edge where waitrequest is seen low
    wire wr = avs_write & !avs_waitrequest;
    assign deep_cmd  = wr && avs_address == `LPMC_ADDR_CMD && avs_writedata[1:0] == `LPMC_CMD_DEEP;
    assign light_cmd = wr && avs_address == `LPMC_ADDR_CMD && avs_writedata[1:0] == `LPMC_CMD_LIGHT;
    wire deep_go  = deep_cmd && state == LPMC_RUN && !stop_disable; // [RL10]
    wire light_go = light_cmd && state == LPMC_RUN;

    // Secondary and primary external interrupt detection
    always_comb begin
        p_req = primary_irq_edge_select ? (pin_p_d & !pin_p)     // [RL18]
                                        : (!pin_p);              // [RL15]
        for (int i = 0; i < 2; i++) begin
            logic cur;
            logic prv;
            cur = (i == 0) ? pin_a : pin_b;
            prv = (i == 0) ? pin_a_d : pin_b_d;
            case (lpmc_sens_e'(sec_sens[i]))
                LPMC_SENS_LOW:  s_req[i] = !cur;
                LPMC_SENS_HIGH: s_req[i] = cur;
                LPMC_SENS_FALL: s_req[i] = prv & !cur;
                LPMC_SENS_RISE: s_req[i] = !prv & cur;
                default:        s_req[i] = 1'b0;
            endcase
            s_req[i] = s_req[i] & sec_en[i]; // [RL16]
        end
        ext_req = p_req | s_req[0] | s_req[1];
    end
    assign timer_irq = (core_timer_ctrl_status[`LPMC_CORE_TIMER_OVERFLOW_FLAG_BIT] & core_timer_ctrl_status[`LPMC_CORE_TIMER_OVERFLOW_ENABLE_BIT])
                     | (core_timer_ctrl_status[`LPMC_REALTIME_INTERRUPT_FLAG_BIT] & core_timer_ctrl_status[`LPMC_REALTIME_INTERRUPT_ENABLE_BIT]);

    // Power state machine
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state    <= LPMC_RUN;
            stab_cnt <= 32'h0;
        end else if (srst) begin
            state    <= LPMC_RUN; // [RL2]
            stab_cnt <= 32'h0;
        end else begin
            case (state)
                LPMC_RUN: begin
                    if (deep_go)
                        state <= LPMC_DEEP;
                    else if (light_go)
                        state <= LPMC_LIGHT; // [RL11]
                end
                LPMC_LIGHT: begin
                    if (timer_irq || serial_irq || prog_timer_irq || ext_req)
                        state <= LPMC_RUN; // [RL12] [RL14]
                end
                LPMC_DEEP: begin
                    if (ext_req) begin // [RL9]
                        state    <= LPMC_STAB;
                        stab_cnt <= 32'h0;
                    end
                end
                LPMC_STAB: begin
                    stab_cnt <= stab_cnt + 32'h1;
                    if (stab_cnt == 32'(STAB_CYC - 1))
                        state <= LPMC_RUN; // [RL19]
                end
                default: state <= LPMC_RUN;
            endcase
        end
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cpu_run <= 1'b1;
            osc_run <= 1'b1;
        end else begin
            cpu_run <= srst || (state == LPMC_RUN && !deep_go && !light_go); // [RL11]
            osc_run <= srst || !(state == LPMC_DEEP || deep_go); // [RL4]
        end
    end

    // Interrupt mask bit
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            int_mask <= 1'b1;
        else if (srst)
            int_mask <= 1'b1;
        else if (deep_go)
            int_mask <= 1'b0; // [RL7]
        else if (light_go)
            int_mask <= 1'b0; // [RL13]
        else if (wr && avs_address == `LPMC_ADDR_CTRL)
            int_mask <= avs_writedata[0];
    end

    // Core timer prescaler and control/status
    wire tick   = bus_clk_en && state != LPMC_DEEP && state != LPMC_STAB;
    wire rti_ev = tick && presc == {`LPMC_PRESC_W{1'b1}};
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            presc <= '0;
        else if (srst || deep_go)
            presc <= '0; // [RL6]
        else if (tick)
            presc <= presc + 1'b1; // [RL11]
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            core_timer_ctrl_status <= 8'h03;
        else if (srst)
            core_timer_ctrl_status <= 8'h03;
        else if (deep_go)
            core_timer_ctrl_status <= core_timer_ctrl_status & 8'h0F; // [RL5] [RL8]
        else begin
            if (wr && avs_address == `LPMC_ADDR_TIMER)
                core_timer_ctrl_status <= {core_timer_ctrl_status[7:6] & ~avs_writedata[7:6], avs_writedata[5:0]};
            if (rti_ev)
                core_timer_ctrl_status[`LPMC_REALTIME_INTERRUPT_FLAG_BIT] <= 1'b1; // [RL14]
            if (tick && presc[`LPMC_RTI_BIT-1:0] == '1)
                core_timer_ctrl_status[`LPMC_CORE_TIMER_OVERFLOW_FLAG_BIT] <= 1'b1;
        end
    end

    // Configuration bits
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            primary_irq_edge_select <= 1'b0;
            sec_sens <= '{2'h0, 2'h0};
            sec_en   <= 2'h0;
            port_dir <= 16'h0000;
        end else if (srst) begin
            primary_irq_edge_select <= 1'b0; // [RL18]
            sec_sens <= '{2'h0, 2'h0};
            sec_en   <= 2'h0;
            port_dir <= 16'h0000; // [RL17]
        end else if (wr && avs_address == `LPMC_ADDR_CTRL) begin
            primary_irq_edge_select <= avs_writedata[1]; // [RL15]
        end else if (wr && avs_address == `LPMC_ADDR_SEC_CFG) begin
            sec_sens[0] <= avs_writedata[1:0]; // [RL16]
            sec_en[0]   <= avs_writedata[2];
            sec_sens[1] <= avs_writedata[5:4];
            sec_en[1]   <= avs_writedata[6];
        end else if (wr && avs_address == `LPMC_ADDR_PORTDIR) begin
            port_dir <= avs_writedata[15:0];
        end
    end

    // Sticky event status, write one to clear, set wins
    assign ev[`LPMC_EV_WAKE_DEEP]  = state == LPMC_STAB && stab_cnt == 32'(STAB_CYC - 1);
    assign ev[`LPMC_EV_WAKE_LIGHT] = state == LPMC_LIGHT &&
        (timer_irq || serial_irq || prog_timer_irq || ext_req);
    assign ev[`LPMC_EV_PRIMARY]    = p_req;
    assign ev[`LPMC_EV_SEC_A]      = s_req[0];
    assign ev[`LPMC_EV_SEC_B]      = s_req[1];
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            status <= '0;
            mask   <= '0;
        end else if (srst) begin
            status <= '0;
            mask   <= '0;
        end else begin
            if (wr && avs_address == `LPMC_ADDR_STATUS)
                status <= (status & ~avs_writedata[`LPMC_EV_N-1:0]) | ev;
            else
                status <= status | ev;
            if (wr && avs_address == `LPMC_ADDR_MASK)
                mask <= avs_writedata[`LPMC_EV_N-1:0];
        end
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            irq <= 1'b0;
        else
            irq <= |((status | ev) & mask);
    end

    // Bus answer one cycle after the request
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0;
        end else begin
            avs_waitrequest <= !(acc);
            if (avs_read && avs_waitrequest) begin
                case (avs_address)
                    `LPMC_ADDR_CTRL:    avs_readdata <= {30'h0, primary_irq_edge_select, int_mask};
                    `LPMC_ADDR_STATUS:  avs_readdata <= {27'h0, status};
                    `LPMC_ADDR_MASK:    avs_readdata <= {27'h0, mask};
                    `LPMC_ADDR_TIMER:   avs_readdata <= {24'h0, core_timer_ctrl_status};
                    `LPMC_ADDR_SEC_CFG: avs_readdata <= {25'h0, sec_en[1], sec_sens[1],
                                                         1'b0, sec_en[0], sec_sens[0]};
                    `LPMC_ADDR_PORTDIR: avs_readdata <= {16'h0, port_dir};
                    `LPMC_ADDR_STATE:   avs_readdata <= {29'h0, state};
                    default:            avs_readdata <= 32'h0;
                endcase
            end
        end
    end

    chk_deep_clears_flags: assert property (@(posedge mclk) disable iff (!reset_n)
        deep_go && !srst |=> core_timer_ctrl_status[7:4] == 4'h0 && presc == '0 && !int_mask) // [RL5]
        else $error("deep sleep entry did not clear timer state");
    chk_deep_no_internal: assert property (@(posedge mclk) disable iff (!reset_n)
        state == LPMC_DEEP && !ext_req && !srst |=> state == LPMC_DEEP) // [RL9]
        else $error("deep sleep left without external cause");
    chk_option_noop: assert property (@(posedge mclk) disable iff (!reset_n)
        state == LPMC_RUN && stop_disable && !light_cmd && !srst |=> state == LPMC_RUN) // [RL10]
        else $error("deep sleep taken while disabled");
    chk_half_rate: assert property (@(posedge mclk) disable iff (!reset_n)
        bus_clk_en |=> !bus_clk_en) // [RL1]
        else $error("bus enable not half rate");
    chk_osc_stopped: assert property (@(posedge mclk) disable iff (!reset_n)
        state == LPMC_DEEP && !srst |-> ##1 !osc_run) // [RL4]
        else $error("oscillator runs in deep sleep");
    chk_light_wake: assert property (@(posedge mclk) disable iff (!reset_n)
        state == LPMC_LIGHT && timer_irq && !srst |=> state == LPMC_RUN) // [RL12]
        else $error("timer did not wake light sleep");
    chk_port_inputs: assert property (@(posedge mclk) disable iff (!reset_n)
        srst |=> port_dir == 16'h0000 && !primary_irq_edge_select) // [RL17]
        else $error("reset did not clear port directions");
    chk_light_mask: assert property (@(posedge mclk) disable iff (!reset_n)
        light_go && !srst |=> !int_mask ##1 !cpu_run) // [RL13]
        else $error("light sleep entry wrong");

    // Wake from deep sleep goes through stabilisation first
    sequence s_deep_wake;
        state == LPMC_DEEP && ext_req && !srst;
    endsequence
    sequence s_stab_held;
        state == LPMC_STAB && !cpu_run;
    endsequence
    chk_deep_wake_stab: assert property (@(posedge mclk) disable iff (!reset_n)
        s_deep_wake |=> s_stab_held) // [RL19]
        else $error("deep wake skipped stabilisation");
    chk_stab_cpu_off: assert property (@(posedge mclk) disable iff (!reset_n)
        state == LPMC_STAB |-> !cpu_run) // [RL19]
        else $error("processor runs during stabilisation");
    chk_reset_state: assert property (@(posedge mclk) disable iff (!reset_n)
        srst |=> int_mask && cpu_run && osc_run && state == LPMC_RUN) // [RL2]
        else $error("reset did not restore start-up state");
    chk_light_osc_on: assert property (@(posedge mclk) disable iff (!reset_n)
        state == LPMC_LIGHT |-> osc_run) // [RL11]
        else $error("oscillator stopped in light sleep");
    chk_deep_presc_hold: assert property (@(posedge mclk) disable iff (!reset_n)
        state == LPMC_DEEP && !srst |=> $stable(presc)) // [RL4]
        else $error("prescaler moved in deep sleep");
    chk_option_osc_on: assert property (@(posedge mclk) disable iff (!reset_n)
        state == LPMC_RUN && stop_disable && deep_cmd && !srst |=> osc_run) // [RL10]
        else $error("oscillator stopped while deep sleep disabled");
    chk_irq_level: assert property (@(posedge mclk) disable iff (!reset_n)
        |(status & mask) |=> irq)
        else $error("interrupt output low with unmasked status");
    chk_bus_answer: assert property (@(posedge mclk) disable iff (!reset_n)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered in one cycle");
    chk_bus_release: assert property (@(posedge mclk) disable iff (!reset_n)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
endmodule : lpmc_ctrl

// ===== src/lpmc_defs.svh
// Constants for the low-power mode controller
//Contract
//RL1: Bus clock enable runs at exactly half the oscillator rate.
//RL2: External reset pin, active low, forces the defined start-up state.
//RL3: Internal power-on reset is generated without any external network.
//RL4: Deep sleep stops oscillator, halting timers and watchdog counter.
//RL5: Deep sleep entry clears timer flags and both timer enables.
//RL6: Deep sleep entry clears the core timer prescaler.
//RL7: Deep sleep entry clears the processor interrupt mask bit.
//RL8: Other state, including untouched timer control bits, holds in deep sleep.
//RL9: Only an external interrupt or reset leaves deep sleep.
//RL10: With deep sleep option disabled, deep sleep request acts as no-op.
//RL11: Light sleep halts the processor; timers and serial bus keep running.
//RL12: Enabled timer or serial bus interrupt ends light sleep.
//RL13: Light sleep entry clears interrupt mask; other state unchanged.
//RL14: Core timer interrupt can wake light sleep periodically.
//RL15: Primary external interrupt has two selectable trigger sensitivities.
//RL16: Secondary interrupts have four sensitivities and independent enables.
//RL17: All port pins become inputs after power-on and any reset.
//RL18: Primary edge select set means edge-only; reset clears it.
//RL19: Deep sleep wake waits an oscillator stabilization delay.
`ifndef LPMC_DEFS_SVH
`define LPMC_DEFS_SVH
`define LPMC_ADDR_CTRL      4'h0
`define LPMC_ADDR_STATUS    4'h1
`define LPMC_ADDR_MASK      4'h2
`define LPMC_ADDR_TIMER     4'h3
`define LPMC_ADDR_SEC_CFG   4'h4
`define LPMC_ADDR_PORTDIR   4'h5
`define LPMC_ADDR_STATE     4'h6
`define LPMC_ADDR_CMD       4'h7
`define LPMC_CMD_DEEP       2'h1
`define LPMC_CMD_LIGHT      2'h2
`define LPMC_POR_NS         1000
`define LPMC_POR_CYC        (((`LPMC_POR_NS) + 4) / 5)
`define LPMC_STAB_NS        20000
`define LPMC_STAB_CYC       (((`LPMC_STAB_NS) + 4) / 5)
`define LPMC_PRESC_W        13
`define LPMC_RTI_BIT        12
`define LPMC_CORE_TIMER_OVERFLOW_FLAG_BIT       7
`define LPMC_REALTIME_INTERRUPT_FLAG_BIT       6
`define LPMC_CORE_TIMER_OVERFLOW_ENABLE_BIT      5
`define LPMC_REALTIME_INTERRUPT_ENABLE_BIT       4
`define LPMC_EV_WAKE_DEEP   0
`define LPMC_EV_WAKE_LIGHT  1
`define LPMC_EV_PRIMARY     2
`define LPMC_EV_SEC_A       3
`define LPMC_EV_SEC_B       4
`define LPMC_EV_N           5
`endif

// ===== src/lpmc_pkg.sv
// Types for the low-power mode controller
package lpmc_pkg;
    typedef enum logic [2:0] {LPMC_RUN, LPMC_LIGHT, LPMC_DEEP, LPMC_STAB} lpmc_state_e;
    typedef enum logic [1:0] {LPMC_SENS_LOW, LPMC_SENS_HIGH, LPMC_SENS_FALL, LPMC_SENS_RISE}
        lpmc_sens_e;
endpackage : lpmc_pkg

// ===== tb/lpmc_ctrl_tb_top.sv
// Self-checking bench for the low-power mode controller
`timescale 1ns/10ps
`include "lpmc_defs.svh"
module lpmc_ctrl_tb_top
    import lpmc_pkg::*;
;
    typedef struct {logic [31:0] exp; logic [31:0] msk;} lpmc_note_s;
    logic        mclk, reset_n, stop_disable, serial_irq, prog_timer_irq;
    logic        ext_reset_n, pri_n, sec_a, sec_b;
    logic [3:0]  avs_address;
    logic        avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata;
    logic        bus_clk_en, cpu_run, osc_run, int_mask, sys_reset_n, irq;
    logic [15:0] port_dir;
    lpmc_note_s  notes[$];
    int          bad_count, check_count, cyc_count;

    lpmc_ctrl #(.STAB_CYC(8)) dut (.mclk(mclk), .reset_n(reset_n), .ext_reset_n(ext_reset_n),
        .stop_disable(stop_disable), .primary_ext_interrupt(pri_n),
        .secondary_ext_interrupt_a(sec_a), .secondary_ext_interrupt_b(sec_b),
        .serial_irq(serial_irq), .prog_timer_irq(prog_timer_irq), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .bus_clk_en(bus_clk_en), .cpu_run(cpu_run), .osc_run(osc_run), .int_mask(int_mask),
        .port_dir(port_dir), .sys_reset_n(sys_reset_n), .irq(irq));
    lpmc_pin_model pins (.mclk(mclk), .ext_reset_n(ext_reset_n), .pri_n(pri_n),
        .sec_a(sec_a), .sec_b(sec_b));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic bit_chk(input string nm, input logic s, input logic e);
        check(nm, {31'h0, s}, {31'h0, e});
    endtask : bit_chk

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= 1'b1;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask : wr

    // Expected value noted first; the monitor compares it
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        notes.push_back('{e, m});
        @(posedge mclk);
        avs_address <= a;
        avs_read    <= 1'b1;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
    endtask : rd

    task automatic cyc(input int c);
        repeat (c) @(posedge mclk);
    endtask : cyc

    task automatic wait_for(input int lim, ref logic sig, input logic v, output int n);
        n = 0;
        while (sig !== v && n < lim) begin
            @(posedge mclk);
            n++;
        end
    endtask : wait_for

    task automatic count_en(input int c, output int n);
        n = 0;
        repeat (c) begin
            @(posedge mclk);
            n += (bus_clk_en === 1'b1);
        end
    endtask : count_en

    always @(posedge mclk) begin : monitor
        lpmc_note_s n;
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            n = notes.pop_front();
            check("readdata", avs_readdata & n.msk, n.exp & n.msk);
        end
    end

    always @(posedge mclk) begin
        cyc_count++;
        if (cyc_count == 60000) begin
            bad_count++;
            give_verdict();
        end
    end

    initial begin : main
        int          n;
        int          k;
        logic [15:0] dir;
        void'($urandom(64274));
        reset_n = 1'b0;
        stop_disable = 1'b0;
        serial_irq = 1'b0;
        prog_timer_irq = 1'b0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        cyc(20);
        reset_n <= 1'b1;
        cyc(3);
        bit_chk("sys_reset_n", sys_reset_n, 1'b0);
        check("port_dir", port_dir, 32'h0);
        wait_for(400, sys_reset_n, 1'b1, n);
        bit_chk("por end", n < 400, 1'b1);
        rd(`LPMC_ADDR_CTRL, 32'h1, 32'h3);
        rd(`LPMC_ADDR_PORTDIR, 32'h0, 32'hFFFF);
        rd(4'hF, 32'h0, 32'hFFFFFFFF);
        count_en(20, n);
        check("bus_clk_en", n, 32'hA);
        // Deep sleep entry with live state
        dir = 16'($urandom());
        wr(`LPMC_ADDR_PORTDIR, {16'h0, dir});
        wr(`LPMC_ADDR_TIMER, 32'h31);
        wr(`LPMC_ADDR_CTRL, 32'h1);
        rd(`LPMC_ADDR_TIMER, 32'h31, 32'h3F);
        wr(`LPMC_ADDR_CMD, {30'h0, `LPMC_CMD_DEEP});
        cyc(4);
        bit_chk("osc_run", osc_run, 1'b0);
        bit_chk("cpu_run", cpu_run, 1'b0);
        bit_chk("int_mask", int_mask, 1'b0);
        check("port_dir", port_dir, dir);
        count_en(8, n);
        check("bus_clk_en", n, 32'h0);
        serial_irq <= 1'b1;
        prog_timer_irq <= 1'b1;
        cyc(30);
        bit_chk("internal wake", cpu_run | osc_run, 1'b0);
        serial_irq <= 1'b0;
        prog_timer_irq <= 1'b0;
        pins.set_pin(0, 1'b0);
        wait_for(100, osc_run, 1'b1, n);
        wait_for(100, cpu_run, 1'b1, n);
        bit_chk("stab delay", n >= 7 && n < 100, 1'b1);
        pins.set_pin(0, 1'b1);
        rd(`LPMC_ADDR_TIMER, 32'h01, 32'h3F);
        rd(`LPMC_ADDR_PORTDIR, {16'h0, dir}, 32'hFFFF);
        rd(`LPMC_ADDR_STATUS, 32'h1, 32'h1);
        // Deep sleep option off
        stop_disable <= 1'b1;
        wr(`LPMC_ADDR_CTRL, 32'h1);
        wr(`LPMC_ADDR_CMD, {30'h0, `LPMC_CMD_DEEP});
        cyc(4);
        bit_chk("osc_run", osc_run, 1'b1);
        bit_chk("int_mask", int_mask, 1'b1);
        rd(`LPMC_ADDR_STATE, {29'h0, LPMC_RUN}, 32'h7);
        stop_disable <= 1'b0;
        // Light sleep, woken by serial bus, then by 16-bit timer, then by core timer
        for (k = 0; k < 3; k++) begin
            wr(`LPMC_ADDR_TIMER, (k == 2) ? 32'hF3 : 32'hC3);
            wr(`LPMC_ADDR_CTRL, 32'h1);
            wr(`LPMC_ADDR_STATUS, 32'h1F);
            wr(`LPMC_ADDR_CMD, {30'h0, `LPMC_CMD_LIGHT});
            cyc(4);
            bit_chk("cpu_run", cpu_run, 1'b0);
            bit_chk("osc_run", osc_run, 1'b1);
            bit_chk("int_mask", int_mask, 1'b0);
            check("port_dir", port_dir, dir);
            count_en(8, n);
            check("bus_clk_en", n, 32'h4);
            serial_irq <= (k == 0);
            prog_timer_irq <= (k == 1);
            wait_for(20000, cpu_run, 1'b1, n);
            bit_chk("light wake", n < ((k == 2) ? 20000 : 20), 1'b1);
            serial_irq <= 1'b0;
            prog_timer_irq <= 1'b0;
            rd(`LPMC_ADDR_STATUS, 32'h2, 32'h2);
        end
        wr(`LPMC_ADDR_TIMER, 32'hC3);
        // Primary pin, edge-only then level
        wr(`LPMC_ADDR_MASK, 32'h4);
        wr(`LPMC_ADDR_CTRL, 32'h2);
        pins.set_pin(0, 1'b0);
        cyc(6);
        bit_chk("irq", irq, 1'b1);
        wr(`LPMC_ADDR_STATUS, 32'h4);
        cyc(4);
        rd(`LPMC_ADDR_STATUS, 32'h0, 32'h4);
        wr(`LPMC_ADDR_CTRL, 32'h0);
        cyc(4);
        rd(`LPMC_ADDR_STATUS, 32'h4, 32'h4);
        pins.set_pin(0, 1'b1);
        cyc(4);
        wr(`LPMC_ADDR_STATUS, 32'h4);
        cyc(2);
        bit_chk("irq", irq, 1'b0);
        // Secondary pins, every sensitivity on each
        for (k = 0; k < 8; k++) begin
            wr(`LPMC_ADDR_MASK, 32'h8 << (k / 4));
            wr(`LPMC_ADDR_SEC_CFG, 32'(4 + k % 4) << (4 * (k / 4)));
            pins.set_pin(1 + k / 4, ~k[0]);
            cyc(6);
            wr(`LPMC_ADDR_STATUS, 32'h1F);
            cyc(2);
            bit_chk("irq idle", irq, 1'b0);
            pins.set_pin(1 + k / 4, k[0]);
            cyc(6);
            rd(`LPMC_ADDR_STATUS, 32'h8 << (k / 4), 32'h18);
            bit_chk("irq", irq, 1'b1);
            pins.set_pin(1 + k / 4, ~k[0]);
            cyc(6);
            wr(`LPMC_ADDR_STATUS, 32'h1F);
        end
        wr(`LPMC_ADDR_SEC_CFG, 32'h40);
        pins.set_pin(1, 1'b0);
        cyc(6);
        rd(`LPMC_ADDR_STATUS, 32'h0, 32'h8);
        pins.set_pin(1, 1'b1);
        // Reset pin
        pins.set_pin(3, 1'b0);
        cyc(6);
        bit_chk("sys_reset_n", sys_reset_n, 1'b0);
        check("port_dir", port_dir, 32'h0);
        pins.set_pin(3, 1'b1);
        wait_for(400, sys_reset_n, 1'b1, n);
        rd(`LPMC_ADDR_CTRL, 32'h1, 32'h3);
        rd(`LPMC_ADDR_PORTDIR, 32'h0, 32'hFFFF);
        give_verdict();
    end
endmodule : lpmc_ctrl_tb_top

// ===== tb/lpmc_pin_model.sv
// External interrupt and reset pin drivers facing the controller
`timescale 1ns/10ps
module lpmc_pin_model (
    input  wire logic mclk,        // Oscillator clock
    output logic      ext_reset_n, // Reset pin, active low
    output logic      pri_n,       // Primary interrupt pin, active low
    output logic      sec_a,       // Secondary interrupt pin a
    output logic      sec_b        // Secondary interrupt pin b
);
    initial begin
        ext_reset_n = 1'b1;
        pri_n       = 1'b1;
        sec_a       = 1'b1;
        sec_b       = 1'b1;
    end

    // Pin 0 primary, 1 secondary a, 2 secondary b, 3 reset
    task automatic set_pin(input int idx, input logic v);
        @(posedge mclk);
        case (idx)
            0: pri_n <= v;
            1: sec_a <= v;
            2: sec_b <= v;
            default: ext_reset_n <= v;
        endcase
    endtask : set_pin
endmodule : lpmc_pin_model
